//--- common/srd_map.svh
// constants for the serial-memory pin-signalling reset detector and its controller
// Summary of operation
// - pattern detected in single, dual or quad mode
// - reset reloads status and configuration defaults
// - host holds serial clock still throughout
// - data line falls with select; others ignored
// - host raises select while data still held
// - four pulses, data level alternates each step
// - reset starts at fourth select rise only
// - host recovers hung device with this pattern
// - deep power-down clears error count and trap
// - leaving hibernate reloads every register default
`ifndef SRD_MAP_SVH
`define SRD_MAP_SVH

`define SRD_PCLK_MHZ 50
`define SRD_STEPS 3'h4
`define SRD_RST_NS 1000
`define SRD_RST_CYCLES ((`SRD_RST_NS * `SRD_PCLK_MHZ + 999) / 1000)
`define SRD_STEP_NS 200
`define SRD_STEP_CYCLES ((`SRD_STEP_NS * `SRD_PCLK_MHZ) / 1000)

`define SRD_SR1_DEF 8'h00
`define SRD_SR2_DEF 8'h00
`define SRD_CR_DEF 8'h00
`define SRD_ECC_DEF 8'h00
`define SRD_TRAP_DEF 24'h000000
`define SRD_CR_MODE_LSB 0

`define SRD_SEL_SR1 3'h0
`define SRD_SEL_SR2 3'h1
`define SRD_SEL_CR0 3'h2
`define SRD_SEL_ECC 3'h6
`define SRD_SEL_TRAP 3'h7

`define SRD_OFF_CTRL 12'h000
`define SRD_OFF_STATUS 12'h004
`define SRD_OFF_DIV 12'h008
`define SRD_CTRL_START 0
`define SRD_CTRL_SCK 1
`define SRD_STAT_BUSY 0
`define SRD_STAT_DONE 1

`endif

//--- common/srd_pkg.sv
// types shared by both ends of the reset pattern link
package srd_pkg;
	typedef enum logic [1:0] {
		SRD_IDLE = 2'h0,
		SRD_LOW = 2'h1,
		SRD_HIGH = 2'h3,
		SRD_RST = 2'h2
	} srd_det_e;

	typedef enum logic [1:0] {
		SRD_H_IDLE = 2'h0,
		SRD_H_PRE = 2'h1,
		SRD_H_LOW = 2'h3,
		SRD_H_HIGH = 2'h2
	} srd_hst_e;

	typedef enum logic [1:0] {
		SRD_MODE_SINGLE = 2'h0,
		SRD_MODE_DUAL = 2'h1,
		SRD_MODE_QUAD = 2'h2
	} srd_mode_e;
endpackage

//--- common/srd_if.sv
// pins between the host controller and the memory device
`timescale 1ns/1ns
interface srd_if;
	logic cs_n;
	logic sck;
	logic [3:0] h_io_o;
	logic [3:0] h_io_oe;
	logic [3:0] d_io_o;
	logic [3:0] d_io_oe;
	logic [3:0] io;

	// pull-up when nobody drives; device wins a contention
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			io[i] = d_io_oe[i] ? d_io_o[i] : (h_io_oe[i] ? h_io_o[i] : 1'b1);
		end
	end

	modport host (output cs_n, output sck, output h_io_o, output h_io_oe, input io);
	modport device (input cs_n, input sck, input io, output d_io_o, output d_io_oe);
endinterface

//--- logic/srd_device.sv
// device end: pin-signalling reset detector with the register defaults it restores
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "srd_map.svh"
module srd_device #(
	parameter int RST_CYCLES = `SRD_RST_CYCLES,
	parameter int TRAP_W = 24
) (
	input wire logic pclk, // core clock
	input wire logic presetn, // async reset, active low
	srd_if.device link, // serial pins
	input wire logic [3:0] core_io_o, // data the command logic wants to drive
	input wire logic [3:0] core_io_oe, // its output enables
	input wire logic reg_we, // register write strobe
	input wire logic [2:0] reg_sel, // register select
	input wire logic [TRAP_W-1:0] reg_wdata, // write data
	input wire logic dpd_i, // deep power-down level
	input wire logic hbn_i, // hibernate level
	output logic [7:0] primary_status_reg_q, // status register 1
	output logic [7:0] secondary_status_reg_q, // status register 2
	output logic [7:0] configuration_regs_q [4], // configuration registers
	output logic [7:0] ecc_error_count_reg_q, // error count
	output logic [TRAP_W-1:0] error_address_trap_reg_q, // error address trap
	output srd_pkg::srd_mode_e io_mode_q, // active I/O protocol
	output logic detecting_q, // pattern partly seen
	output logic reset_busy_q, // reset in progress
	output logic reset_done_q // one-cycle pulse at reset end
);

	localparam int CW = $clog2(RST_CYCLES + 1);

	// expected first-data-line level right after select falls in a step
	function automatic logic expect_lvl(input logic [1:0] step);
		return step[0];
	endfunction

	function automatic srd_pkg::srd_mode_e mode_of(input logic [7:0] cr);
		case (cr[`SRD_CR_MODE_LSB +: 2])
			2'h1: return srd_pkg::SRD_MODE_DUAL;
			2'h2: return srd_pkg::SRD_MODE_QUAD;
			default: return srd_pkg::SRD_MODE_SINGLE;
		endcase
	endfunction

	// bit 2 select, bit 1 clock, bit 0 first data line
	logic [2:0] meta_q;
	logic [2:0] sync_q;
	logic [2:0] prev_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= 3'h7;
			sync_q <= 3'h7;
			prev_q <= 3'h7;
		end else begin
			meta_q <= {link.cs_n, link.sck, link.io[0]};
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	logic cs_fall;
	logic cs_rise;
	logic sck_move;
	logic io0_move;
	logic io0_lvl;
	assign cs_fall = prev_q[2] & ~sync_q[2];
	assign cs_rise = ~prev_q[2] & sync_q[2];
	assign sck_move = prev_q[1] ^ sync_q[1];
	assign io0_move = prev_q[0] ^ sync_q[0];
	assign io0_lvl = sync_q[0];

	srd_pkg::srd_det_e state_q;
	logic [1:0] step_q;
	logic [CW-1:0] cnt_q;

	// detection never looks at io_mode_q, so any protocol mode is covered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= srd_pkg::SRD_IDLE;
			step_q <= 2'h0;
		end else begin
			case (state_q)
				srd_pkg::SRD_IDLE: begin
					if (cs_fall && io0_lvl == expect_lvl(2'h0)) begin
						state_q <= srd_pkg::SRD_LOW;
						step_q <= 2'h0;
					end
				end
				srd_pkg::SRD_LOW: begin
					if (sck_move || io0_move) begin
						state_q <= srd_pkg::SRD_IDLE;
					end else if (cs_rise) begin
						if (step_q == 2'(`SRD_STEPS - 3'h1)) begin
							state_q <= srd_pkg::SRD_RST;
						end else begin
							state_q <= srd_pkg::SRD_HIGH;
							step_q <= step_q + 2'h1;
						end
					end
				end
				srd_pkg::SRD_HIGH: begin
					if (sck_move) begin
						state_q <= srd_pkg::SRD_IDLE;
					end else if (cs_fall) begin
						if (io0_lvl == expect_lvl(step_q)) begin
							state_q <= srd_pkg::SRD_LOW;
						end else if (io0_lvl == expect_lvl(2'h0)) begin
							// a wrong level may itself open a fresh sequence
							state_q <= srd_pkg::SRD_LOW;
							step_q <= 2'h0;
						end else begin
							state_q <= srd_pkg::SRD_IDLE;
						end
					end
				end
				srd_pkg::SRD_RST: begin
					if (cnt_q == CW'(1)) begin
						state_q <= srd_pkg::SRD_IDLE;
						step_q <= 2'h0;
					end
				end
				default: state_q <= srd_pkg::SRD_IDLE;
			endcase
		end
	end

	logic rst_start;
	assign rst_start = state_q == srd_pkg::SRD_LOW && !sck_move && !io0_move && cs_rise
		&& step_q == 2'(`SRD_STEPS - 3'h1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
			reset_busy_q <= 1'b0;
			reset_done_q <= 1'b0;
		end else begin
			reset_done_q <= 1'b0;
			if (rst_start) begin
				cnt_q <= CW'(RST_CYCLES);
				reset_busy_q <= 1'b1;
			end else if (cnt_q != '0) begin
				cnt_q <= cnt_q - CW'(1);
				if (cnt_q == CW'(1)) begin
					reset_busy_q <= 1'b0;
					reset_done_q <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			detecting_q <= 1'b0;
		end else begin
			detecting_q <= state_q == srd_pkg::SRD_LOW || state_q == srd_pkg::SRD_HIGH;
		end
	end

	// pins tristated while a pattern may be under way or a reset runs
	logic quiet;
	assign quiet = state_q != srd_pkg::SRD_IDLE || rst_start;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link.d_io_o <= 4'h0;
			link.d_io_oe <= 4'h0;
		end else begin
			link.d_io_o <= core_io_o;
			link.d_io_oe <= quiet ? 4'h0 : core_io_oe;
		end
	end

	logic hbn_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hbn_q <= 1'b0;
		end else begin
			hbn_q <= hbn_i;
		end
	end

	logic hbn_exit;
	logic full_load;
	logic wr_ok;
	assign hbn_exit = hbn_q & ~hbn_i;
	assign full_load = rst_start || hbn_exit;
	// writes from the command side are dropped while a reset runs
	assign wr_ok = reg_we && state_q != srd_pkg::SRD_RST;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			primary_status_reg_q <= `SRD_SR1_DEF;
			secondary_status_reg_q <= `SRD_SR2_DEF;
			for (int i = 0; i < 4; i++) begin
				configuration_regs_q[i] <= `SRD_CR_DEF;
			end
		end else if (full_load) begin
			primary_status_reg_q <= `SRD_SR1_DEF;
			secondary_status_reg_q <= `SRD_SR2_DEF;
			for (int i = 0; i < 4; i++) begin
				configuration_regs_q[i] <= `SRD_CR_DEF;
			end
		end else if (wr_ok) begin
			if (reg_sel == `SRD_SEL_SR1) begin
				primary_status_reg_q <= reg_wdata[7:0];
			end
			if (reg_sel == `SRD_SEL_SR2) begin
				secondary_status_reg_q <= reg_wdata[7:0];
			end
			for (int i = 0; i < 4; i++) begin
				if (reg_sel == `SRD_SEL_CR0 + 3'(i)) begin
					configuration_regs_q[i] <= reg_wdata[7:0];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ecc_error_count_reg_q <= `SRD_ECC_DEF;
			error_address_trap_reg_q <= TRAP_W'(`SRD_TRAP_DEF);
		end else if (full_load || dpd_i) begin
			ecc_error_count_reg_q <= `SRD_ECC_DEF;
			error_address_trap_reg_q <= TRAP_W'(`SRD_TRAP_DEF);
		end else if (wr_ok) begin
			if (reg_sel == `SRD_SEL_ECC) begin
				ecc_error_count_reg_q <= reg_wdata[7:0];
			end
			if (reg_sel == `SRD_SEL_TRAP) begin
				error_address_trap_reg_q <= reg_wdata;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			io_mode_q <= srd_pkg::SRD_MODE_SINGLE;
		end else if (full_load) begin
			io_mode_q <= mode_of(`SRD_CR_DEF);
		end else if (wr_ok && reg_sel == `SRD_SEL_CR0) begin
			io_mode_q <= mode_of(reg_wdata[7:0]);
		end
	end

endmodule

//--- logic/srd_host.sv
// host end: APB-controlled generator of the pin-signalling reset pattern
`timescale 1ns/1ns
`include "srd_map.svh"
module srd_host #(
	parameter int STEP_CYCLES = `SRD_STEP_CYCLES
) (
	input wire logic pclk, // core clock
	input wire logic presetn, // async reset, active low
	srd_if.host link, // serial pins
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr // APB error, unmapped address
);

	srd_pkg::srd_hst_e st_q;
	logic [1:0] step_q;
	logic [15:0] div_q;
	logic [15:0] tmr_q;
	logic sck_lvl_q;
	logic done_q;

	function automatic logic mapped(input logic [11:0] a);
		return a == `SRD_OFF_CTRL || a == `SRD_OFF_STATUS || a == `SRD_OFF_DIV;
	endfunction

	logic access;
	logic commit;
	logic wr_fire;
	logic start;
	assign access = psel && penable && !pready;
	// writes land only on the edge that completes the transfer
	assign commit = psel && penable && pready;
	assign wr_fire = commit && pwrite && paddr == `SRD_OFF_CTRL;
	assign start = wr_fire && pwdata[`SRD_CTRL_START] && st_q == srd_pkg::SRD_H_IDLE;

	// one wait state keeps pready straight from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= access;
			pslverr <= access && !mapped(paddr);
			prdata <= 32'h00000000;
			if (access && !pwrite) begin
				case (paddr)
					`SRD_OFF_CTRL: prdata[`SRD_CTRL_SCK] <= sck_lvl_q;
					`SRD_OFF_STATUS: prdata[1:0] <= {done_q, st_q != srd_pkg::SRD_H_IDLE};
					`SRD_OFF_DIV: prdata[15:0] <= div_q;
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_lvl_q <= 1'b0;
			div_q <= 16'(STEP_CYCLES);
		end else if (commit && pwrite) begin
			if (paddr == `SRD_OFF_CTRL && st_q == srd_pkg::SRD_H_IDLE) begin
				sck_lvl_q <= pwdata[`SRD_CTRL_SCK];
			end
			if (paddr == `SRD_OFF_DIV && pwdata[15:0] != 16'h0000) begin
				div_q <= pwdata[15:0];
			end
		end
	end

	logic tick;
	assign tick = tmr_q == 16'h0001;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= srd_pkg::SRD_H_IDLE;
			step_q <= 2'h0;
			tmr_q <= 16'h0000;
			done_q <= 1'b0;
			link.cs_n <= 1'b1;
			link.sck <= 1'b0;
			link.h_io_o <= 4'h0;
			link.h_io_oe <= 4'h0;
		end else begin
			link.sck <= sck_lvl_q;
			if (tmr_q != 16'h0000) begin
				tmr_q <= tmr_q - 16'h0001;
			end
			case (st_q)
				srd_pkg::SRD_H_IDLE: begin
					link.cs_n <= 1'b1;
					link.h_io_oe <= 4'h0;
					if (start) begin
						st_q <= srd_pkg::SRD_H_PRE;
						step_q <= 2'h0;
						tmr_q <= div_q;
						done_q <= 1'b0;
						link.h_io_o <= 4'h1;
						link.h_io_oe <= 4'h1;
						// new level reaches the pin on the same edge the frame opens
						link.sck <= pwdata[`SRD_CTRL_SCK];
					end
				end
				srd_pkg::SRD_H_PRE, srd_pkg::SRD_H_HIGH: begin
					if (tick) begin
						st_q <= srd_pkg::SRD_H_LOW;
						tmr_q <= div_q;
						link.cs_n <= 1'b0;
						link.h_io_o <= {3'h0, step_q[0]};
					end
				end
				srd_pkg::SRD_H_LOW: begin
					if (tick) begin
						link.cs_n <= 1'b1;
						tmr_q <= div_q;
						if (step_q == 2'(`SRD_STEPS - 3'h1)) begin
							st_q <= srd_pkg::SRD_H_IDLE;
							done_q <= 1'b1;
						end else begin
							st_q <= srd_pkg::SRD_H_HIGH;
							step_q <= step_q + 2'h1;
						end
					end
				end
				default: st_q <= srd_pkg::SRD_H_IDLE;
			endcase
		end
	end

endmodule

//--- testbench/srd_props.sv
// checker for the host-to-device reset pattern pins
`timescale 1ns/1ns
module srd_props (
	input wire logic pclk, // core clock
	input wire logic presetn, // async reset, active low
	input wire logic cs_n, // select
	input wire logic sck, // serial clock
	input wire logic [3:0] h_io_o, // host data
	input wire logic [3:0] h_io_oe, // host enables
	input wire logic [3:0] d_io_oe, // device enables
	input wire logic [3:0] io // resolved lines
);
	logic cs_d_q;
	logic [2:0] falls_q;
	wire fall = cs_d_q && !cs_n;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cs_d_q <= 1'b1;
		end else begin
			cs_d_q <= cs_n;
		end
	end
	// falls counted per frame; a frame is the host owning the data line
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			falls_q <= 3'h0;
		end else if (!h_io_oe[0]) begin
			falls_q <= 3'h0;
		end else if (fall) begin
			falls_q <= falls_q + 3'h1;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_sck_low; !cs_n && !$past(cs_n) |-> $stable(sck); endproperty
	property p_sck_frame; h_io_oe[0] && $past(h_io_oe[0]) |-> $stable(sck); endproperty
	property p_first; fall && falls_q == 3'h0 |-> !io[0] && $past(io[0]); endproperty
	property p_pre; $rose(h_io_oe[0]) |-> cs_n && h_io_o[0]; endproperty
	property p_hold; !cs_n && !$past(cs_n) |-> $stable(io[0]); endproperty
	property p_alt; fall |-> io[0] == falls_q[0]; endproperty
	property p_four; fall |-> falls_q < 3'h4; endproperty
	property p_end; $rose(cs_n) && falls_q == 3'h4 |-> ##[1:3] (!h_io_oe[0] && cs_n); endproperty
	// device sees select through a synchroniser, so quiet from the second step on
	property p_hiz; !cs_n && falls_q > 3'h1 |-> d_io_oe == 4'h0; endproperty
	a_sck_low: assert property (p_sck_low) else $error("clock moved while selected");
	a_sck_frame: assert property (p_sck_frame) else $error("clock moved in frame");
	a_first: assert property (p_first) else $error("data did not fall with select");
	a_pre: assert property (p_pre) else $error("frame not opened high");
	a_hold: assert property (p_hold) else $error("data moved while selected");
	a_alt: assert property (p_alt) else $error("data level not alternating");
	a_four: assert property (p_four) else $error("more than four pulses");
	a_end: assert property (p_end) else $error("frame not closed after last pulse");
	a_hiz: assert property (p_hiz) else $error("device drove data while selected");
	c_frame: cover property ($rose(cs_n) && falls_q == 3'h4);
	c_sck_hi: cover property (fall && sck);
	c_sck_lo: cover property (fall && !sck);
endmodule

//--- testbench/spi_signaling_reset_detector_tb.sv
// self-checking bench: host end drives device end, second device faces bench pins
`timescale 1ns/1ns
`include "srd_map.svh"
module spi_signaling_reset_detector_tb;
	logic pclk, presetn, psel, penable, pwrite, pslverr, pready, reg_we, dpd_i, hbn_i, busy, busy2, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] reg_sel;
	logic [23:0] reg_wdata, trap;
	logic [7:0] sr1, sr2, ecc;
	logic [7:0] cfg [4];
	srd_pkg::srd_mode_e mode;
	int fail_count = 0, checks = 0, cyc = 0, rises = 0, busy_at = 0, blen = 0, b2 = 0, n;
	int dcnt = 0, dones = 0;
	logic det, done_p;
	logic [3:0] core_o, core_oe;
	srd_if lnk();
	srd_if lnk2();
	srd_host #(.STEP_CYCLES(4)) i_srd_host (.pclk(pclk), .presetn(presetn), .link(lnk), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	srd_device #(.RST_CYCLES(4)) i_srd_device (.pclk(pclk), .presetn(presetn), .link(lnk), .core_io_o(core_o),
		.core_io_oe(core_oe), .reg_we(reg_we), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .dpd_i(dpd_i), .hbn_i(hbn_i),
		.primary_status_reg_q(sr1), .secondary_status_reg_q(sr2), .configuration_regs_q(cfg),
		.ecc_error_count_reg_q(ecc), .error_address_trap_reg_q(trap), .io_mode_q(mode), .detecting_q(det),
		.reset_busy_q(busy), .reset_done_q(done_p));
	srd_device #(.RST_CYCLES(4)) i_srd_device_b (.pclk(pclk), .presetn(presetn), .link(lnk2), .core_io_o(core_o),
		.core_io_oe(core_oe), .reg_we(reg_we), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .dpd_i(dpd_i), .hbn_i(hbn_i),
		.primary_status_reg_q(), .secondary_status_reg_q(), .configuration_regs_q(), .ecc_error_count_reg_q(),
		.error_address_trap_reg_q(), .io_mode_q(), .detecting_q(), .reset_busy_q(busy2), .reset_done_q());
	srd_props i_srd_props (.pclk(pclk), .presetn(presetn), .cs_n(lnk.cs_n), .sck(lnk.sck), .h_io_o(lnk.h_io_o),
		.h_io_oe(lnk.h_io_oe), .d_io_oe(lnk.d_io_oe), .io(lnk.io));
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if ($rose(lnk.cs_n)) rises <= rises + 1;
		if ($rose(busy)) begin
			busy_at <= rises;
			blen <= 1;
		end else if (busy) blen <= blen + 1;
		if ($rose(busy2)) b2 <= b2 + 1;
		if (det) dcnt <= dcnt + 1;
		if (done_p) dones <= dones + 1;
		if (cyc == 20000) begin
			fail_count++;
			end_sim;
		end
	end
	task cmp(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task wreg(input logic [2:0] s, input logic [23:0] v);
		@(posedge pclk);
		reg_we <= 1'b1; reg_sel <= s; reg_wdata <= v;
		@(posedge pclk);
		reg_we <= 1'b0;
	endtask
	task fill(input logic [1:0] m);
		wreg(3'h0, 24'hA5); wreg(3'h1, 24'h3C); wreg(3'h2, {22'h0, m}); wreg(3'h5, 24'h77);
		wreg(3'h6, 24'h11); wreg(3'h7, 24'h123456);
		repeat (2) @(posedge pclk);
	endtask
	task chk_def;
		cmp({sr1, sr2, cfg[0], cfg[1]}, {`SRD_SR1_DEF, `SRD_SR2_DEF, `SRD_CR_DEF, `SRD_CR_DEF});
		cmp({cfg[2], cfg[3], ecc, 8'h00}, {`SRD_CR_DEF, `SRD_CR_DEF, `SRD_ECC_DEF, 8'h00});
		cmp({8'h00, trap}, {8'h00, `SRD_TRAP_DEF});
		cmp(32'(mode), 32'(srd_pkg::SRD_MODE_SINGLE));
	endtask
	task run_host(input logic sk);
		int r0, d0, e0;
		r0 = rises;
		d0 = dcnt;
		e0 = dones;
		apb(1'b1, `SRD_OFF_CTRL, {30'h0, sk, 1'b1});
		rd = 32'h0;
		while (rd[1] !== 1'b1) apb(1'b0, `SRD_OFF_STATUS, 32'h0);
		cmp(rd, 32'h2);
		repeat (10) @(posedge pclk);
		cmp(32'(busy_at - r0), 32'h4);
		cmp(32'(blen), 32'h4);
		cmp({31'h0, lnk.sck}, {31'h0, sk});
		cmp(32'(dcnt - d0), 32'((2 * 4 - 1) * 4));
		cmp(32'(dones - e0), 32'h1);
		cmp({24'h0, lnk.d_io_oe, lnk.io}, {24'h0, core_oe, core_o[3:1], 1'b1});
	endtask
	// bench plays the pattern itself so it can break it on purpose
	task frame(input int k);
		// a clock move flushes any partial sequence the last frame left behind
		lnk2.sck <= ~lnk2.sck;
		lnk2.h_io_o[0] <= 1'b1;
		repeat (6) @(posedge pclk);
		for (int s = 0; s < 4; s++) begin
			lnk2.cs_n <= 1'b0;
			lnk2.h_io_o[0] <= s[0] ^ (k == 0 && s == 2);
			repeat (4) @(posedge pclk);
			if (s == k && k == 1) lnk2.sck <= ~lnk2.sck;
			if (s == k && k == 2) lnk2.h_io_o[0] <= ~s[0];
			repeat (4) @(posedge pclk);
			lnk2.cs_n <= 1'b1;
			repeat (6) @(posedge pclk);
		end
		repeat (12) @(posedge pclk);
	endtask
	task end_sim;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
		reg_we = 1'b0; reg_sel = 3'h0; reg_wdata = 24'h0; dpd_i = 1'b0; hbn_i = 1'b0;
		lnk2.cs_n = 1'b1; lnk2.sck = 1'b0; lnk2.h_io_o = 4'hF; lnk2.h_io_oe = 4'h1;
		core_o = 4'hA;
		core_oe = 4'hE;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk_def;
		apb(1'b0, 12'h0FC, 32'h0);
		cmp({rd[31:1], err}, 32'h1);
		apb(1'b1, `SRD_OFF_DIV, 32'h4);
		apb(1'b0, `SRD_OFF_DIV, 32'h0);
		cmp(rd, 32'h4);
		for (int i = 0; i < 3; i++) begin
			fill(i[1:0]);
			cmp(32'(mode), 32'(i));
			run_host(i[0]);
			chk_def;
		end
		fill(2'h0);
		dpd_i <= 1'b1;
		repeat (3) @(posedge pclk);
		cmp({ecc, trap}, 32'h0);
		dpd_i <= 1'b0;
		repeat (3) @(posedge pclk);
		cmp({ecc, trap}, 32'h0);
		fill(2'h2);
		hbn_i <= 1'b1;
		repeat (3) @(posedge pclk);
		hbn_i <= 1'b0;
		repeat (3) @(posedge pclk);
		chk_def;
		for (int k = 0; k < 3; k++) begin
			n = b2;
			frame(k);
			cmp(32'(b2 - n), 32'h0);
			frame(3);
			cmp(32'(b2 - n), 32'h1);
		end
		end_sim;
	end
endmodule
